// File: verilog/mcs_misc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module mcs_misc_ctrl
	import mcs_pkg::*;
#(
	parameter int TB0_CYCLES = TB0_CYC,
	parameter int TB1_CYCLES = TB1_CYC,
	parameter int DR_CYCLES  = DR_CYC,
	parameter int ST_CYCLES  = ST_CYC,
	parameter int MEM_CYCLES = MEM_CYC
)
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire mcs_spi_t    spi_in,
	input  wire logic        ext_clk_in,
	input  wire mcs_st_res_t st_result_in,
	input  wire logic        mem_fail_in,
	input  wire logic        flash_write_in,
	output var  logic        spi_dout_out,
	output var  logic        digital_line_1_out,
	output var  logic        digital_line_1_oe_out,
	output var  logic        digital_line_2_out,
	output var  logic        digital_line_2_oe_out,
	output var  logic        sample_tick_out,
	output var  logic        stim_pos_out,
	output var  logic        stim_neg_out,
	output var  logic        bias_comp_en_out,
	output var  logic        align_en_out,
	output var  logic [11:0] dac_code_out
);
	logic [3:0]  sync1_r;
	logic [3:0]  sync2_r;
	logic [3:0]  prev_r;
	logic        cs_fall;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        ext_rise;
	logic [3:0]  bit_cnt_r;
	logic        seen_r;
	logic [15:0] rx_r;
	logic [15:0] tx_r;
	logic [15:0] rd_word_r;
	logic [15:0] word;
	logic        frame_done;
	logic        wr_en;
	logic        rd_en;
	logic [6:0]  addr;
	logic [15:0] rd_mux;
	logic [15:0] misc_r;
	logic [15:0] misc_nxt;
	logic [11:0] aux_r;
	logic [7:0]  smpl_r;
	logic [15:0] nv_cnt_r;
	logic [15:0] diag_r;
	logic [15:0] diag_set;
	mcs_st_res_t st_res_r;
	logic        mem_fail_r;
	mcs_test_t   state_r;
	logic [23:0] test_cnt_r;
	logic        self_done;
	logic        mem_done;
	logic        ext_mode;
	logic [22:0] tb_cnt_r;
	logic [6:0]  ns_cnt_r;
	logic        tick_int;
	logic [15:0] dr_cnt_r;
	logic        dr_active_r;
	logic        dr_level;

	// Pin synchronisers: {ext clock, select, serial clock, serial data}
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sync1_r <= 4'h6;
			sync2_r <= 4'h6;
			prev_r  <= 4'h6;
		end
		else
		begin
			sync1_r <= {ext_clk_in, spi_in.cs_n, spi_in.sclk, spi_in.din};
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	assign cs_fall   = prev_r[2] & ~sync2_r[2];
	assign sclk_rise = ~prev_r[1] & sync2_r[1] & ~sync2_r[2];
	assign sclk_fall = prev_r[1] & ~sync2_r[1] & ~sync2_r[2];
	assign ext_rise  = ~prev_r[3] & sync2_r[3];

	// Serial link, 16-bit frames, data in on rising and out on falling
	assign word       = {rx_r[14:0], sync2_r[0]};
	assign frame_done = sclk_rise & (bit_cnt_r == 4'hF);
	assign wr_en      = frame_done & word[15];
	assign rd_en      = frame_done & ~word[15];
	assign addr       = word[14:8];

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			bit_cnt_r    <= 4'h0;
			seen_r       <= 1'b0;
			rx_r         <= 16'h0000;
			tx_r         <= 16'h0000;
			spi_dout_out <= 1'b0;
		end
		else if (cs_fall)
		begin
			bit_cnt_r    <= 4'h0;
			seen_r       <= 1'b0;
			spi_dout_out <= rd_word_r[15];
			tx_r         <= {rd_word_r[14:0], 1'b0};
		end
		else if (sclk_rise)
		begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
			seen_r    <= 1'b1;
			rx_r      <= word;
		end
		else if (sclk_fall && seen_r)
		begin
			spi_dout_out <= tx_r[15];
			tx_r         <= {tx_r[14:0], 1'b0};
		end
	end

	always_comb
	begin
		unique case ({addr[6:1], 1'b0})
			ADDR_NV_CNT:  rd_mux = nv_cnt_r;
			ADDR_AUX_DAC: rd_mux = {4'h0, aux_r};
			ADDR_MISC:    rd_mux = misc_r & MSC_MASK;
			ADDR_SMPL:    rd_mux = {8'h00, smpl_r};
			ADDR_DIAG:    rd_mux = diag_r;
			default:      rd_mux = 16'h0000;
		endcase
	end

	// Read answer goes out in the next frame
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			rd_word_r <= 16'h0000;
		else if (rd_en)
			rd_word_r <= rd_mux;
	end

	// Control register with self-clearing test bits
	always_comb
	begin
		misc_nxt = misc_r;
		if (self_done)
			misc_nxt[MSC_SELFTEST] = 1'b0;
		if (mem_done)
			misc_nxt[MSC_MEMTEST] = 1'b0;
		if (wr_en && addr == ADDR_MISC)
			misc_nxt[7:0] = word[7:0];
		if (wr_en && addr == (ADDR_MISC | 7'h01))
			misc_nxt[15:8] = word[7:0];
		misc_nxt = misc_nxt & MSC_MASK;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			misc_r <= MSC_RESET;
		else
			misc_r <= misc_nxt;
	end

	assign stim_neg_out     = misc_r[MSC_STIM_NEG];
	assign stim_pos_out     = misc_r[MSC_STIM_POS];
	assign bias_comp_en_out = misc_r[MSC_BIAS];
	assign align_en_out     = misc_r[MSC_ALIGN];

	// Analog level register and latch command
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			aux_r        <= 12'h000;
			dac_code_out <= 12'h000;
		end
		else
		begin
			if (wr_en && addr == ADDR_AUX_DAC)
				aux_r[7:0] <= word[7:0];
			if (wr_en && addr == (ADDR_AUX_DAC | 7'h01))
				aux_r[11:8] <= word[3:0];
			if (wr_en && addr == ADDR_GLOB && word[GLOB_DAC_LAT])
				dac_code_out <= aux_r;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			smpl_r <= SMPL_RESET;
		else if (wr_en && addr == ADDR_SMPL)
			smpl_r <= word[7:0];
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			nv_cnt_r <= 16'h0000;
		else if (flash_write_in)
			nv_cnt_r <= nv_cnt_r + 16'h0001;
	end

	// Test sequencer: self-test has priority over memory test
	assign self_done = (state_r == T_SELF) && (test_cnt_r == 24'h0);
	assign mem_done  = (state_r == T_MEM) && (test_cnt_r == 24'h0);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r    <= T_IDLE;
			test_cnt_r <= 24'h0;
		end
		else
		begin
			unique case (state_r)
				T_IDLE:
				begin
					if (misc_r[MSC_SELFTEST])
					begin
						state_r    <= T_SELF;
						test_cnt_r <= 24'(ST_CYCLES - 1);
					end
					else if (misc_r[MSC_MEMTEST])
					begin
						state_r    <= T_MEM;
						test_cnt_r <= 24'(MEM_CYCLES - 1);
					end
				end
				T_SELF, T_MEM:
				begin
					if (test_cnt_r == 24'h0)
						state_r <= T_IDLE;
					else
						test_cnt_r <= test_cnt_r - 24'h1;
				end
				default:
					state_r <= T_IDLE;
			endcase
		end
	end

	// Verdict latches keep a failure alive across flag reads
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_res_r   <= '0;
			mem_fail_r <= 1'b0;
		end
		else
		begin
			if (self_done)
				st_res_r <= st_result_in;
			if (mem_done)
				mem_fail_r <= mem_fail_in;
		end
	end

	always_comb
	begin
		diag_set = 16'h0000;
		if (self_done)
		begin
			diag_set[DIAG_ST_ERR]         = st_result_in.any_fail;
			diag_set[DIAG_GYRO]           = st_result_in.gyro_fail;
			diag_set[DIAG_X_ACC+2:DIAG_X_ACC] = {st_result_in.z_fail,
				st_result_in.y_fail, st_result_in.x_fail};
		end
		if (mem_done)
			diag_set[DIAG_CKSUM] = mem_fail_in;
		if (sample_tick_out)
		begin
			diag_set[DIAG_ST_ERR] |= st_res_r.any_fail;
			diag_set[DIAG_GYRO]   |= st_res_r.gyro_fail;
			diag_set[DIAG_CKSUM]  |= mem_fail_r;
			diag_set[DIAG_X_ACC+2:DIAG_X_ACC] |= {st_res_r.z_fail,
				st_res_r.y_fail, st_res_r.x_fail};
		end
	end

	// A read clears the flags, but a same-cycle set still lands
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			diag_r <= 16'h0000;
		else if (rd_en && {addr[6:1], 1'b0} == ADDR_DIAG)
			diag_r <= diag_set;
		else
			diag_r <= diag_r | diag_set;
	end

	// Sample timing: internal time base or external clock edges
	assign ext_mode = (smpl_r == 8'h00);
	assign tick_int = (tb_cnt_r == 23'h0) && (ns_cnt_r == 7'h0);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tb_cnt_r <= 23'h0;
			ns_cnt_r <= 7'h0;
		end
		else if (ext_mode)
		begin
			tb_cnt_r <= 23'h0;
			ns_cnt_r <= 7'h0;
		end
		else if (tb_cnt_r != 23'h0)
			tb_cnt_r <= tb_cnt_r - 23'h1;
		else
		begin
			tb_cnt_r <= smpl_r[SMPL_TB_SEL] ? 23'(TB1_CYCLES - 1)
				: 23'(TB0_CYCLES - 1);
			ns_cnt_r <= (ns_cnt_r == 7'h0) ? smpl_r[6:0]
				: ns_cnt_r - 7'h1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			sample_tick_out <= 1'b0;
		else
			sample_tick_out <= ext_mode ? ext_rise : tick_int;
	end

	// Data-ready pulse follows the posted sample by one cycle
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			dr_active_r <= 1'b0;
			dr_cnt_r    <= 16'h0;
		end
		else if (sample_tick_out)
		begin
			dr_active_r <= 1'b1;
			dr_cnt_r    <= 16'h0;
		end
		else if (dr_active_r)
		begin
			dr_cnt_r <= dr_cnt_r + 16'h1;
			if (dr_cnt_r == 16'(DR_CYCLES - 1))
				dr_active_r <= 1'b0;
		end
	end

	assign dr_level = dr_active_r ^ ~misc_r[MSC_DR_POL];

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			digital_line_1_out    <= 1'b0;
			digital_line_1_oe_out <= 1'b0;
			digital_line_2_out    <= 1'b0;
			digital_line_2_oe_out <= 1'b0;
		end
		else
		begin
			digital_line_1_out    <= dr_level;
			digital_line_2_out    <= dr_level;
			digital_line_1_oe_out <= misc_r[MSC_DR_EN] & ~misc_r[MSC_DR_LINE];
			digital_line_2_oe_out <= misc_r[MSC_DR_EN] & misc_r[MSC_DR_LINE];
		end
	end

	a_ext_sample: assert property (@(posedge clk_in) disable iff (rst_in)
		ext_mode && ext_rise |=> sample_tick_out)
		else $error("external edge did not give a sample");
	a_dr_start: assert property (@(posedge clk_in) disable iff (rst_in)
		sample_tick_out |=> dr_active_r && dr_cnt_r == 16'h0)
		else $error("data-ready did not start after sample");
	a_dr_width: assert property (@(posedge clk_in) disable iff (rst_in)
		$fell(dr_active_r) |-> $past(dr_cnt_r) == 16'(DR_CYCLES - 1)
			&& DR_CYCLES <= DR_MAX_CYC)
		else $error("data-ready pulse width wrong");
	a_dr_route: assert property (@(posedge clk_in) disable iff (rst_in)
		##1 digital_line_2_oe_out == ($past(misc_r[MSC_DR_EN])
			&& $past(misc_r[MSC_DR_LINE])) && !(digital_line_1_oe_out && digital_line_2_oe_out))
		else $error("data-ready routed to wrong line");
	a_self_clear: assert property (@(posedge clk_in) disable iff (rst_in)
		self_done && !wr_en |=> !misc_r[MSC_SELFTEST] && state_r == T_IDLE)
		else $error("self-test bit not cleared at end");
	a_mem_clear: assert property (@(posedge clk_in) disable iff (rst_in)
		mem_done && !wr_en |=> !misc_r[MSC_MEMTEST])
		else $error("memory test bit not cleared at end");
	a_st_flags: assert property (@(posedge clk_in) disable iff (rst_in)
		self_done |=> diag_r[DIAG_GYRO] == $past(st_result_in.gyro_fail)
			|| $past(diag_r[DIAG_GYRO]))
		else $error("self-test verdict not posted");
	a_dac_latch: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_en && addr == ADDR_GLOB && word[GLOB_DAC_LAT]
			|=> dac_code_out == $past(aux_r))
		else $error("latch did not move the level code");
	a_nv_count: assert property (@(posedge clk_in) disable iff (rst_in)
		flash_write_in |=> nv_cnt_r == $past(nv_cnt_r) + 16'h0001)
		else $error("write counter did not advance");
	a_diag_clear: assert property (@(posedge clk_in) disable iff (rst_in)
		rd_en && {addr[6:1], 1'b0} == ADDR_DIAG && diag_set == 16'h0
			|=> diag_r == 16'h0)
		else $error("flag read did not clear flags");
	a_unused_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		misc_r[15:12] == 4'h0 && misc_r[5:3] == 3'h0)
		else $error("unused control bits not zero");
endmodule
`default_nettype wire

// File: verilog/mcs_pkg.sv
`default_nettype none
package mcs_pkg;
	// Serial word addresses (write frame: bit 15 set, address, data byte)
	localparam logic [6:0] ADDR_NV_CNT   = 7'h00;
	localparam logic [6:0] ADDR_AUX_DAC  = 7'h30;
	localparam logic [6:0] ADDR_MISC     = 7'h34;
	localparam logic [6:0] ADDR_SMPL     = 7'h36;
	localparam logic [6:0] ADDR_DIAG     = 7'h3C;
	localparam logic [6:0] ADDR_GLOB     = 7'h3E;
	// Field positions
	localparam int MSC_DR_LINE  = 0;
	localparam int MSC_DR_POL   = 1;
	localparam int MSC_DR_EN    = 2;
	localparam int MSC_ALIGN    = 6;
	localparam int MSC_BIAS     = 7;
	localparam int MSC_STIM_POS = 8;
	localparam int MSC_STIM_NEG = 9;
	localparam int MSC_SELFTEST = 10;
	localparam int MSC_MEMTEST  = 11;
	localparam int GLOB_DAC_LAT = 2;
	localparam int DIAG_ST_ERR  = 5;
	localparam int DIAG_CKSUM   = 6;
	localparam int DIAG_GYRO    = 10;
	localparam int DIAG_X_ACC   = 13;
	localparam int SMPL_TB_SEL  = 7;
	// Masks and reset values
	localparam logic [15:0] MSC_MASK  = 16'h0FC7;
	localparam logic [15:0] DAC_MASK  = 16'h0FFF;
	localparam logic [15:0] MSC_RESET = 16'h0006;
	localparam logic [7:0]  SMPL_RESET = 8'h01;
	// Timing, in ns, and derived counts at the system clock
	localparam int CLK_NS     = 4;
	localparam int TB0_NS     = 610350;
	localparam int TB1_NS     = 18921000;
	localparam int DR_MIN_NS  = 100000;
	localparam int DR_MAX_NS  = 200000;
	localparam int ST_NS      = 35000000;
	localparam int MEM_NS     = 20000000;
	localparam int TB0_CYC    = TB0_NS / CLK_NS;
	localparam int TB1_CYC    = TB1_NS / CLK_NS;
	localparam int DR_CYC     = (DR_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int DR_MAX_CYC = DR_MAX_NS / CLK_NS;
	localparam int ST_CYC     = ST_NS / CLK_NS;
	localparam int MEM_CYC    = MEM_NS / CLK_NS;
	// Link pins as one group
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} mcs_spi_t;
	// Per-sensor self-test verdicts from the measurement path
	typedef struct packed {
		logic z_fail;
		logic y_fail;
		logic x_fail;
		logic gyro_fail;
		logic any_fail;
	} mcs_st_res_t;
	typedef enum logic [1:0] {
		T_IDLE = 2'b00,
		T_SELF = 2'b01,
		T_MEM  = 2'b11
	} mcs_test_t;
endpackage
`default_nettype wire

// File: verif/mcs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module mcs_host_model
	import mcs_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        dout_in,
	output var  mcs_spi_t    spi_out,
	output var  logic [15:0] rd_out,
	output var  logic        rd_vld_out
);
	initial
	begin
		spi_out = 3'b110;
		rd_out = 16'h0000;
		rd_vld_out = 1'b0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Mode 3 frame, MSB first; clock rests high between frames
	task automatic xfer(input logic [15:0] w, input int hp, input bit rd);
		cyc(1);
		spi_out.cs_n = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			cyc(hp);
			spi_out.sclk = 1'b0;
			spi_out.din = w[i];
			cyc(hp);
			spi_out.sclk = 1'b1;
			rd_out[i] = dout_in;
		end
		cyc(hp);
		spi_out.cs_n = 1'b1;
		// Released data line must not look like a held bit
		spi_out.din = ~spi_out.din;
		rd_vld_out = rd;
		cyc(1);
		rd_vld_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
	import mcs_pkg::*;
;
	localparam int DRP  = 25;
	localparam int STP  = 3000;
	localparam int MEMP = 2000;
	logic        clk_in   = 1'b0;
	logic        rst_in   = 1'b1;
	logic        ext_clk  = 1'b0;
	mcs_st_res_t st_res   = '0;
	logic        mem_fail = 1'b0;
	logic        fl_wr    = 1'b0;
	mcs_spi_t    spi;
	logic        dout, d1, d1oe, d2, d2oe, tck, sp, sn, bc, al, rdv;
	logic [11:0] dac;
	logic [15:0] rdw, v, mlo, fl;
	logic [15:0] exp_q[$];
	string       nm_q[$];
	int          errors       = 0;
	int          total_checks = 0;
	int          seed         = 98103;
	int          ticks        = 0;
	int          k, c0;

	mcs_misc_ctrl #(.TB0_CYCLES(100), .TB1_CYCLES(400), .DR_CYCLES(DRP),
		.ST_CYCLES(STP), .MEM_CYCLES(MEMP)) i_mcs_misc_ctrl (
		.clk_in(clk_in), .rst_in(rst_in), .spi_in(spi), .ext_clk_in(ext_clk),
		.st_result_in(st_res), .mem_fail_in(mem_fail),
		.flash_write_in(fl_wr), .spi_dout_out(dout), .digital_line_1_out(d1),
		.digital_line_1_oe_out(d1oe), .digital_line_2_out(d2), .digital_line_2_oe_out(d2oe),
		.sample_tick_out(tck), .stim_pos_out(sp), .stim_neg_out(sn),
		.bias_comp_en_out(bc), .align_en_out(al), .dac_code_out(dac));
	mcs_host_model i_mcs_host_model (.clk_in(clk_in), .dout_in(dout),
		.spi_out(spi), .rd_out(rdw), .rd_vld_out(rdv));

	initial
	begin
		forever #2 clk_in = ~clk_in;
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_mcs_host_model.xfer({1'b1, a, d}, 20, 1'b0);
	endtask
	// Answer comes in the following frame
	task automatic rd(input logic [6:0] a, input logic [15:0] e, input string n);
		exp_q.push_back(e);
		nm_q.push_back(n);
		i_mcs_host_model.xfer({1'b0, a, 8'h00}, 20, 1'b0);
		i_mcs_host_model.xfer(16'h0000, 20, 1'b1);
	endtask
	always @(posedge clk_in)
	begin
		if (rdv === 1'b1)
			chk(nm_q.pop_front(), exp_q.pop_front(), rdw);
		if (tck === 1'b1)
			ticks++;
	end
	task automatic drchk(input logic [2:0] c);
		int n;
		int act;
		n = 0;
		act = 0;
		while (tck !== 1'b1 && n < 2000)
		begin
			cyc(1);
			n++;
		end
		if (n == 2000)
		begin
			errors++;
			complete_run();
		end
		chk("line1 oe", {15'h0, c[2] & ~c[0]}, {15'h0, d1oe});
		chk("line2 oe", {15'h0, c[2] & c[0]}, {15'h0, d2oe});
		for (int i = 0; i < DRP + 4; i++)
		begin
			cyc(1);
			act += ((c[0] ? d2 : d1) === c[1]);
		end
		if (c[2])
			chk("pulse cycles", 16'(DRP), 16'(act));
	endtask

	initial
	begin
		#400000;
		errors++;
		complete_run();
	end
	initial
	begin
		repeat (10) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		cyc(5);
		rd(ADDR_MISC, MSC_RESET, "misc");
		drchk(3'b110);
		rd(ADDR_AUX_DAC, 16'h0000, "level");
		v = 16'h0000;
		for (int c = 0; c < 8; c++)
		begin
			v[7:0] = 8'($random(seed));
			v[2:0] = 3'(c);
			wr(ADDR_MISC, v[7:0]);
			chk("bias", {15'h0, v[7]}, {15'h0, bc});
			chk("align", {15'h0, v[6]}, {15'h0, al});
			drchk(v[2:0]);
			rd(ADDR_MISC, v & MSC_MASK, "misc");
		end
		mlo = v & MSC_MASK;
		wr(ADDR_MISC + 7'h01, 8'hF3);
		cyc(DRP);
		chk("stim pos", 16'h0001, {15'h0, sp});
		chk("stim neg", 16'h0001, {15'h0, sn});
		rd(ADDR_MISC, 16'h0300 | mlo, "misc");
		wr(ADDR_MISC + 7'h01, 8'h00);
		chk("stim both", 16'h0000, {14'h0, sp, sn});
		v = 16'($random(seed));
		wr(ADDR_AUX_DAC, v[7:0]);
		wr(ADDR_AUX_DAC + 7'h01, v[15:8]);
		chk("dac early", 16'h0000, {4'h0, dac});
		rd(ADDR_AUX_DAC, v & DAC_MASK, "level");
		wr(ADDR_GLOB, 8'h04);
		cyc(5);
		chk("dac latched", v & DAC_MASK, {4'h0, dac});
		rd(ADDR_GLOB, 16'h0000, "command");
		k = 1 + ($random(seed) & 7);
		repeat (k)
		begin
			fl_wr = 1'b1;
			cyc(1);
			fl_wr = 1'b0;
			cyc(2);
		end
		rd(ADDR_NV_CNT, 16'(k), "count");
		st_res = 5'($random(seed));
		wr(ADDR_MISC + 7'h01, 8'h04);
		rd(ADDR_MISC, 16'h0400 | mlo, "misc busy");
		cyc(STP);
		rd(ADDR_MISC, mlo, "misc done");
		fl = {st_res.z_fail, st_res.y_fail, st_res.x_fail, 2'b00,
			st_res.gyro_fail, 4'h0, st_res.any_fail, 5'h00};
		rd(ADDR_DIAG, fl, "flags");
		mem_fail = 1'b1;
		wr(ADDR_MISC + 7'h01, 8'h08);
		rd(ADDR_MISC, 16'h0800 | mlo, "misc busy");
		cyc(MEMP);
		rd(ADDR_MISC, mlo, "misc done");
		rd(ADDR_DIAG, fl | 16'h0040, "flags");
		wr(ADDR_SMPL, 8'h00);
		cyc(50);
		c0 = ticks;
		cyc(1000);
		chk("idle ticks", 16'(c0), 16'(ticks));
		repeat (3)
		begin
			ext_clk = 1'b1;
			cyc(100);
			ext_clk = 1'b0;
			cyc(100);
		end
		chk("ext ticks", 16'(c0 + 3), 16'(ticks));
		// Slow time base, two steps: one sample every 800 cycles
		wr(ADDR_SMPL, 8'h81);
		drchk(mlo[2:0]);
		c0 = ticks;
		cyc(2400);
		chk("slow ticks", 16'(c0 + 3), 16'(ticks));
		complete_run();
	end
endmodule
`default_nettype wire
